// *** hw/tss_pkg.sv ***
// Package: register map, field layout and encodings of the transmit source
package tss_pkg;

	// ----------------------------------------------------------------
	// Register map (printed offset 0x0B is not a multiple of four)
	// ----------------------------------------------------------------
	localparam logic [7:0]  TX_MODE_IDX      = 8'h0B;
	localparam logic [11:0] TX_MODE_ADDR     = {2'h0, TX_MODE_IDX, 2'h0};
	localparam logic [11:0] SYM_STAT_ADDR    = 12'h040;
	localparam logic [11:0] PULSE_PER_ADDR   = 12'h044;
	localparam logic [7:0]  TX_MODE_RST      = 8'h00;
	localparam logic [15:0] PULSE_PER_RST    = 16'h0000;
	localparam logic [31:0] RD_ZERO          = 32'h0000_0000;

	// ----------------------------------------------------------------
	// Field positions of the transmitter mode control register
	// ----------------------------------------------------------------
	localparam int SRC_LSB   = 0;
	localparam int SRC_MSB   = 2;
	localparam int POLY_BIT  = 3;
	localparam int MUTE_BIT  = 4;
	localparam int PLVL_LSB  = 5;
	localparam int PLVL_MSB  = 6;
	localparam int MODE_W    = 7;

	// ----------------------------------------------------------------
	// Scrambler taps and line levels
	// ----------------------------------------------------------------
	localparam int LFSR_LEN   = 23;
	localparam int TAP_REMOTE = 18;
	localparam int TAP_LOCAL  = 5;

	// Line level as signed 3-bit: -3,-1,0,+1,+3
	localparam logic [2:0] LVL_ZERO = 3'h0;
	localparam logic [2:0] LVL_P1   = 3'h1;
	localparam logic [2:0] LVL_P3   = 3'h3;
	localparam logic [2:0] LVL_M1   = 3'h7;
	localparam logic [2:0] LVL_M3   = 3'h5;

	// Source select codes
	typedef enum logic [2:0] {
		SRC_PULSE    = 3'h0,
		SRC_LOOP     = 3'h1,
		SRC_RAW4     = 3'h2,
		SRC_ONES4    = 3'h3,
		SRC_RSVD     = 3'h4,
		SRC_SCR4     = 3'h5,
		SRC_RAW2     = 3'h6,
		SRC_ONES2    = 3'h7
	} tss_src_t;

	// Map sign and magnitude to a line level
	function automatic logic [2:0] tss_quat(input logic sgn, input logic mag);
		logic [2:0] lvl;
		lvl = LVL_ZERO;
		unique case ({sgn, mag})
			2'b10: lvl = LVL_P3;
			2'b11: lvl = LVL_P1;
			2'b00: lvl = LVL_M3;
			2'b01: lvl = LVL_M1;
		endcase
		return lvl;
	endfunction

endpackage

// *** hw/tss_scr_if.sv ***
// Interface: scrambler request and result between the top and the LFSR
`timescale 1ns/1ps
interface tss_scr_if;
	logic       step;
	logic       single;
	logic       remote;
	logic [1:0] din;
	logic [1:0] dout;

	// Single asks for one scrambler bit per symbol instead of two
	modport ctrl (output step, output single, output remote, output din,
		input dout);
	modport scr  (input step, input single, input remote, input din,
		output dout);
endinterface

// *** hw/tss_scrambler.sv ***
// Self-synchronising transmit scrambler, two bits or one per symbol
`timescale 1ns/1ps
module tss_scrambler
	import tss_pkg::*;
(
	// Clock and reset
	input  wire logic ref_clk,
	input  wire logic rst,
	// Request and result
	tss_scr_if.scr    sif
);

	logic [LFSR_LEN-1:0] hist_ff;
	logic [LFSR_LEN-1:0] nxt_hist;
	logic [1:0]          scr_bits;

	// ----------------------------------------------------------------
	// Scramble: sign bit first (older), then magnitude bit
	// ----------------------------------------------------------------
	always_comb begin
		logic [LFSR_LEN-1:0] h;
		logic [LFSR_LEN-1:0] h_one;
		h = hist_ff;
		h_one = hist_ff;
		scr_bits = 2'h0;
		for (int i = 1; i >= 0; i--) begin
			scr_bits[i] = sif.din[i] ^ h[LFSR_LEN-1] ^
				(sif.remote ? h[TAP_REMOTE-1] : h[TAP_LOCAL-1]);
			h = {h[LFSR_LEN-2:0], scr_bits[i]};
			if (i == 1) begin
				h_one = h;
			end
		end
		// symbol rate run keeps only the sign bit
		nxt_hist = hist_ff;
		if (sif.step) begin
			nxt_hist = sif.single ? h_one : h;
		end
	end

	// History holds only while no symbol is scrambled
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			hist_ff <= '0;
		end else begin
			hist_ff <= nxt_hist;
		end
	end

	assign sif.dout = scr_bits;

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	// Self-sync only works if the history is built from sent bits
	hist_load_a: assert property (
		@(posedge ref_clk) disable iff (rst)
		sif.step && !sif.single |=> hist_ff[1:0] == $past(sif.dout))
		else $error("scrambler history not loaded");

	one_step_a: assert property (
		@(posedge ref_clk) disable iff (rst)
		sif.step && sif.single |=> hist_ff[0] == $past(sif.dout[1]))
		else $error("single step history wrong");

endmodule

// *** hw/tss_top.sv ***
// Transmit symbol source selector and scrambler with APB registers
//
// Summary of operation
// - Pulse level code selects -3,-1,+3,+1
// - Mute bit forces output level zero
// - Remote select picks taps 23/18, else 23/5
// - Source modes reach the line only while unmuted; the scrambler still steps on every symbol
// - Code 000 sends pulses at timer period
// - Code 001 scrambles detector decisions back
// - Code 010 sends channel bits unscrambled
// - Code 011 sends scrambled constant ones
// - Code 101 scrambles channel bits and sends
// - Code 110 sends sign only, magnitude zero
`timescale 1ns/1ps
module tss_top
	import tss_pkg::*;
#(
	parameter int PER_W = 16
)(
	// Clock and reset
	input  wire logic        ref_clk,
	input  wire logic        rst,
	// APB slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic             pready,
	output logic [31:0]      prdata,
	output logic             pslverr,
	// Symbol stream
	input  wire logic        sym_tick,
	input  wire logic        ch_sign,
	input  wire logic        ch_mag,
	input  wire logic        det_sign,
	input  wire logic        det_mag,
	// Transmit DAC
	output logic [2:0]       tx_level,
	output logic             tx_valid
);

	// ----------------------------------------------------------------
	// Declarations
	// ----------------------------------------------------------------
	logic [MODE_W-1:0] mode_ff,   nxt_mode;
	logic [PER_W-1:0]  per_ff,    nxt_per;
	logic [PER_W-1:0]  cnt_ff,    nxt_cnt;
	logic [2:0]        lvl_ff,    nxt_lvl;
	logic              vld_ff,    nxt_vld;
	logic              rdy_ff,    nxt_rdy;
	logic              err_ff,    nxt_err;
	logic [31:0]       rd_ff,     nxt_rd;
	logic              acc;
	logic              hit;
	tss_src_t          src;
	logic              mute;
	logic              pulse_now;
	logic [1:0]        scr_in;

	tss_scr_if scr_bus ();

	tss_scrambler u_scr (
		.ref_clk (ref_clk),
		.rst     (rst),
		.sif     (scr_bus)
	);

	assign src  = tss_src_t'(mode_ff[SRC_MSB:SRC_LSB]);
	assign mute = mode_ff[MUTE_BIT];

	// Address decode used only for the slave error flag; read and write paths compare paddr directly
	function automatic logic addr_ok(input logic [11:0] a);
		return (a == TX_MODE_ADDR) || (a == SYM_STAT_ADDR) ||
			(a == PULSE_PER_ADDR);
	endfunction

	// ----------------------------------------------------------------
	// APB slave: one wait state, answer in the second access cycle
	// ----------------------------------------------------------------
	assign acc = psel && penable && !rdy_ff;
	assign hit = addr_ok(paddr);

	always_comb begin
		nxt_mode = mode_ff;
		nxt_per  = per_ff;
		nxt_rdy  = acc;
		nxt_err  = acc && !hit;
		nxt_rd   = rd_ff;
		if (acc && pwrite && paddr == TX_MODE_ADDR) begin
			nxt_mode = pwdata[MODE_W-1:0];
		end
		if (acc && pwrite && paddr == PULSE_PER_ADDR) begin
			nxt_per = pwdata[PER_W-1:0];
		end
		if (acc && !pwrite) begin
			unique case (1'b1)
				paddr == TX_MODE_ADDR:
					nxt_rd = {25'h0, mode_ff};
				paddr == SYM_STAT_ADDR:
					nxt_rd = {28'h0, vld_ff, lvl_ff};
				paddr == PULSE_PER_ADDR:
					nxt_rd = {{(32-PER_W){1'b0}}, per_ff};
				default:
					nxt_rd = RD_ZERO;
			endcase
		end
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			mode_ff <= TX_MODE_RST[MODE_W-1:0];
			per_ff  <= PULSE_PER_RST[PER_W-1:0];
			rdy_ff  <= 1'b0;
			err_ff  <= 1'b0;
			rd_ff   <= RD_ZERO;
		end else begin
			mode_ff <= nxt_mode;
			per_ff  <= nxt_per;
			rdy_ff  <= nxt_rdy;
			err_ff  <= nxt_err;
			rd_ff   <= nxt_rd;
		end
	end

	assign pready  = rdy_ff;
	assign pslverr = err_ff;
	assign prdata  = rd_ff;

	// ----------------------------------------------------------------
	// Pulse period timer: continuous reload countdown on symbol ticks
	// ----------------------------------------------------------------
	// pulse spacing
	// A period of zero fires every symbol; the host owns the interval.
	assign pulse_now = (cnt_ff == '0);

	always_comb begin
		nxt_cnt = cnt_ff;
		if (src != SRC_PULSE || mute) begin
			nxt_cnt = per_ff;
		end else if (sym_tick) begin
			nxt_cnt = pulse_now ? per_ff : cnt_ff - 1'b1;
		end
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			cnt_ff <= '0;
		end else begin
			cnt_ff <= nxt_cnt;
		end
	end

	// ----------------------------------------------------------------
	// Scrambler feed: chosen input bits, stepped once per symbol
	// ----------------------------------------------------------------
	always_comb begin
		scr_in = {ch_sign, ch_mag};
		unique case (src)
			SRC_LOOP:  scr_in = {det_sign, det_mag};
			SRC_ONES4, SRC_ONES2: scr_in = 2'h3;
			default:   scr_in = {ch_sign, ch_mag};
		endcase
	end

	assign scr_bus.din    = scr_in;
	assign scr_bus.remote = mode_ff[POLY_BIT];
	assign scr_bus.step   = sym_tick;
	assign scr_bus.single = (src == SRC_ONES2);

	// ----------------------------------------------------------------
	// Output level selection
	// ----------------------------------------------------------------
	always_comb begin
		nxt_lvl = lvl_ff;
		nxt_vld = sym_tick;
		if (sym_tick) begin
			unique case (src)
				SRC_PULSE: begin
					unique case (mode_ff[PLVL_MSB:PLVL_LSB])
						2'h0: nxt_lvl = LVL_M3;
						2'h1: nxt_lvl = LVL_M1;
						2'h2: nxt_lvl = LVL_P3;
						2'h3: nxt_lvl = LVL_P1;
					endcase
					if (!pulse_now) begin
						nxt_lvl = LVL_ZERO;
					end
				end
				SRC_LOOP, SRC_ONES4, SRC_SCR4:
					nxt_lvl = tss_quat(scr_bus.dout[1], scr_bus.dout[0]);
				SRC_RAW4: nxt_lvl = tss_quat(ch_sign, ch_mag);
				SRC_RAW2: nxt_lvl = tss_quat(ch_sign, 1'b0);
				SRC_ONES2: nxt_lvl = tss_quat(scr_bus.dout[1], 1'b0);
				SRC_RSVD: nxt_lvl = LVL_ZERO;
			endcase
			if (mute) begin
				nxt_lvl = LVL_ZERO;
			end
		end
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			lvl_ff <= LVL_ZERO;
			vld_ff <= 1'b0;
		end else begin
			lvl_ff <= nxt_lvl;
			vld_ff <= nxt_vld;
		end
	end

	assign tx_level = lvl_ff;
	assign tx_valid = vld_ff;

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	sequence sym_muted;
		sym_tick && mute;
	endsequence

	mute_zero_a: assert property (
		@(posedge ref_clk) disable iff (rst)
		sym_muted |=> tx_level == LVL_ZERO && tx_valid)
		else $error("muted symbol not zero");

	src_gate_a: assert property (
		@(posedge ref_clk) disable iff (rst)
		sym_tick && mute && src == SRC_RAW4 |=> tx_level == LVL_ZERO)
		else $error("source active while muted");

	pulse_lvl_a: assert property (
		@(posedge ref_clk) disable iff (rst)
		sym_tick && !mute && src == SRC_PULSE && pulse_now &&
		mode_ff[PLVL_MSB:PLVL_LSB] == 2'h1 |=> tx_level == LVL_M1)
		else $error("pulse level wrong");

	pulse_gap_a: assert property (
		@(posedge ref_clk) disable iff (rst)
		sym_tick && !mute && src == SRC_PULSE && !pulse_now
		|=> tx_level == LVL_ZERO)
		else $error("pulse outside period");

	raw_four_a: assert property (
		@(posedge ref_clk) disable iff (rst)
		sym_tick && !mute && src == SRC_RAW4 && ch_sign && !ch_mag
		|=> tx_level == LVL_P3)
		else $error("raw data level wrong");

	two_level_a: assert property (
		@(posedge ref_clk) disable iff (rst)
		sym_tick && !mute && src == SRC_RAW2 && !ch_sign
		|=> tx_level == LVL_M3)
		else $error("two-level data wrong");

	ones_two_a: assert property (
		@(posedge ref_clk) disable iff (rst)
		sym_tick && !mute && src == SRC_ONES2
		|=> tx_level == LVL_P3 || tx_level == LVL_M3)
		else $error("two-level ones wrong");

	rsvd_zero_a: assert property (
		@(posedge ref_clk) disable iff (rst)
		sym_tick && src == SRC_RSVD |=> tx_level == LVL_ZERO)
		else $error("reserved code not zero");

	scr_map_a: assert property (
		@(posedge ref_clk) disable iff (rst)
		sym_tick && !mute && src == SRC_SCR4
		|=> tx_level == tss_quat($past(scr_bus.dout[1]),
			$past(scr_bus.dout[0])))
		else $error("scrambled level wrong");

	loop_scr_a: assert property (
		@(posedge ref_clk) disable iff (rst)
		sym_tick && !mute && src == SRC_LOOP
		|-> scr_bus.din == {det_sign, det_mag})
		else $error("loopback feed wrong");

	apb_wait_a: assert property ( // one wait state
		@(posedge ref_clk) disable iff (rst)
		psel && penable && !pready |=> pready)
		else $error("apb answer late");

	pulse_plus_a: assert property (
		@(posedge ref_clk) disable iff (rst)
		sym_tick && !mute && src == SRC_PULSE && pulse_now &&
		mode_ff[PLVL_MSB:PLVL_LSB] == 2'h2 |=> tx_level == LVL_P3)
		else $error("pulse plus level wrong");

	raw_neg_a: assert property (
		@(posedge ref_clk) disable iff (rst)
		sym_tick && !mute && src == SRC_RAW4 && !ch_sign && ch_mag
		|=> tx_level == LVL_M1)
		else $error("negative inner level wrong");

	valid_rise_a: assert property (
		@(posedge ref_clk) disable iff (rst)
		sym_tick |=> tx_valid)
		else $error("symbol not marked valid");

	valid_fall_a: assert property (
		@(posedge ref_clk) disable iff (rst)
		!sym_tick |=> !tx_valid)
		else $error("valid without symbol");

	level_hold_a: assert property (
		@(posedge ref_clk) disable iff (rst)
		!sym_tick |=> $stable(tx_level))
		else $error("level moved between symbols");

	ready_once_a: assert property (
		@(posedge ref_clk) disable iff (rst)
		pready |=> !pready)
		else $error("apb ready too long");

	bad_addr_a: assert property (
		@(posedge ref_clk) disable iff (rst)
		psel && penable && !pready && !hit |=> pready && pslverr)
		else $error("unmapped access not flagged");

	// Pulse timer: reload on the firing tick, count down on other ticks
	sequence pulse_fire;
		sym_tick && !mute && src == SRC_PULSE && pulse_now;
	endsequence

	pulse_reload_a: assert property (
		@(posedge ref_clk) disable iff (rst)
		pulse_fire |=> cnt_ff == $past(per_ff))
		else $error("pulse timer not reloaded");

	count_down_a: assert property (
		@(posedge ref_clk) disable iff (rst)
		sym_tick && !mute && src == SRC_PULSE && !pulse_now
		|=> cnt_ff == $past(cnt_ff) - 1'b1)
		else $error("pulse timer not counting");

endmodule

// *** tb/tss_line_partner.sv ***
// Far-end line model: takes symbols, returns detector decisions
`timescale 1ns/1ps
module tss_line_partner (
	// Clock and reset
	input  wire logic       ref_clk,
	input  wire logic       rst,
	// Line from the transmitter
	input  wire logic [2:0] tx_level,
	input  wire logic       tx_valid,
	// Detector decisions back
	output logic            det_sign,
	output logic            det_mag
);
	logic [1:0] cnt_ff;

	// Decisions advance one quat per received symbol, two when tx_level bit 1 is set
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			cnt_ff <= 2'h0;
		end else if (tx_valid) begin
			cnt_ff <= cnt_ff + 2'h1 + {1'b0, tx_level[1]};
		end
	end

	// Sign and magnitude derived so the pair changes on every step
	assign det_sign = cnt_ff[1] ^ cnt_ff[0];
	assign det_mag  = cnt_ff[0];
endmodule

// *** tb/test_tss_top.sv ***
// Self-checking bench for the transmit source selector
`timescale 1ns/1ps
module test_tss_top;
	import tss_pkg::*;
	logic        ref_clk = 1'b0;
	logic        rst = 1'b1;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0;
	logic        pready;
	logic [31:0] prdata;
	logic        pslverr;
	logic        sym_tick = 1'b0;
	logic        ch_sign = 1'b0;
	logic        ch_mag = 1'b0;
	logic        det_sign;
	logic        det_mag;
	logic [2:0]  tx_level;
	logic        tx_valid;
	int          fails = 0;
	int          checks_done = 0;
	logic [31:0] rd;
	logic        err;
	logic [1:0]  di;
	logic [22:0] h = 23'h0;
	logic [2:0]  pl [4] = '{LVL_M3, LVL_M1, LVL_P3, LVL_P1};

	tss_top #(.PER_W(16)) tss_top_i (.ref_clk(ref_clk), .rst(rst),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .pready(pready), .prdata(prdata),
		.pslverr(pslverr), .sym_tick(sym_tick), .ch_sign(ch_sign),
		.ch_mag(ch_mag), .det_sign(det_sign), .det_mag(det_mag),
		.tx_level(tx_level), .tx_valid(tx_valid));

	tss_line_partner tss_line_partner_i (.ref_clk(ref_clk), .rst(rst),
		.tx_level(tx_level), .tx_valid(tx_valid),
		.det_sign(det_sign), .det_mag(det_mag));

	// 250 MHz clock
	always #2 ref_clk = ~ref_clk;

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			fails++;
			$display("BAD t=%0t seen %h exp %h", $time, seen, exp);
		end
	endtask

	task automatic stop_test();
		$display("checks %0d fails %0d", checks_done, fails);
		if (fails == 0 && checks_done > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	// APB transfer; request held until pready is sampled high
	task automatic apb(input logic w, input logic [11:0] a,
		input logic [31:0] d);
		@(posedge ref_clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge ref_clk);
		penable <= 1'b1;
		// The wait ends when pready is sampled high; if it never is, only the watchdog ends it
		do begin
			@(posedge ref_clk);
		end while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic setm(input logic [6:0] v);
		apb(1'b1, TX_MODE_ADDR, {25'h0, v});
	endtask

	// One symbol; detector bits noted at the edge that samples them
	task automatic sym(input logic s, input logic m);
		@(posedge ref_clk);
		sym_tick <= 1'b1;
		ch_sign <= s;
		ch_mag <= m;
		@(posedge ref_clk);
		di = {det_sign, det_mag};
		sym_tick <= 1'b0;
		#1;
		check(32'(tx_valid), 32'h1);
	endtask

	function automatic logic [2:0] enc(input logic s, input logic m);
		return s ? (m ? LVL_P1 : LVL_P3) : (m ? LVL_M1 : LVL_M3);
	endfunction

	// History rebuilt from the line, since the scrambler self-syncs
	task automatic scr(input logic [2:0] src, input logic rem);
		int t;
		logic [1:0]  d;
		logic [22:0] g;
		t = rem ? TAP_REMOTE : TAP_LOCAL;
		setm({3'h0, rem, src});
		for (int i = 0; i < 40; i++) begin
			sym(i[0], i[2]);
			d = (src == SRC_ONES4) ? 2'h3 : (src == SRC_LOOP) ? di
				: {i[0], i[2]};
			g = {h[21:0], d[1] ^ h[t-1] ^ h[22]};
			d[0] = d[0] ^ g[t-1] ^ g[22];
			if (i >= 12)
				check(32'(tx_level),
					32'(enc(g[0], d[0])));
			h = {h[20:0], tx_level == LVL_P3 || tx_level == LVL_P1,
				tx_level == LVL_P1 || tx_level == LVL_M1};
		end
		$display("test scrambler %0d %0d done", src, rem);
	endtask

	initial begin
		int c;
		int last;
		repeat (6) @(posedge ref_clk);
		rst <= 1'b0;
		apb(1'b0, TX_MODE_ADDR, 32'h0);
		check(rd, 32'(TX_MODE_RST));
		apb(1'b0, PULSE_PER_ADDR, 32'h0);
		check(rd, 32'(PULSE_PER_RST));
		setm(7'h7F);
		apb(1'b1, TX_MODE_ADDR, 32'hFFFF_FFFF);
		apb(1'b0, TX_MODE_ADDR, 32'h0);
		check(rd, 32'h7F);
		apb(1'b0, 12'h100, 32'h0);
		check({rd[30:0], err}, 32'h1);
		// Period timer set up by the host before pulse mode
		apb(1'b1, PULSE_PER_ADDR, 32'h3);
		$display("test registers done");
		for (int k = 0; k < 4; k++) begin
			setm({k[1:0], 2'h0, SRC_PULSE});
			c = 0;
			last = -1;
			for (int i = 0; i < 8; i++) begin
				sym(1'b0, 1'b0);
				if (tx_level !== LVL_ZERO) begin
					check(32'(tx_level), 32'(pl[k]));
					if (last >= 0)
						check(i - last, 32'h4);
					last = i;
					c++;
				end
			end
			check(c, 32'h2);
		end
		$display("test pulses done");
		for (int i = 0; i < 4; i++) begin
			setm({4'h0, SRC_RAW4});
			sym(i[1], i[0]);
			check(32'(tx_level), 32'(enc(i[1], i[0])));
			apb(1'b0, SYM_STAT_ADDR, 32'h0);
			check(rd, 32'(enc(i[1], i[0])));
			setm({4'h2, SRC_RAW4});
			sym(i[1], i[0]);
			check(32'(tx_level), 32'h0);
			setm({4'h0, SRC_RSVD});
			sym(i[1], i[0]);
			check(32'(tx_level), 32'h0);
			setm({4'h0, SRC_RAW2});
			sym(i[1], 1'b1);
			check(32'(tx_level), 32'(enc(i[1], 1'b0)));
		end
		$display("test plain modes done");
		for (int r = 0; r < 2; r++) begin
			scr(SRC_ONES4, r[0]);
			scr(SRC_SCR4, r[0]);
			scr(SRC_LOOP, r[0]);
		end
		// Two-level ones: one scrambler bit per symbol, history from line
		setm({4'h0, SRC_ONES2});
		c = 0;
		for (int i = 0; i < 40; i++) begin
			sym(1'b1, 1'b1);
			h = {h[21:0], 1'b1 ^ h[TAP_LOCAL-1] ^ h[22]};
			check(32'(tx_level == LVL_P3 || tx_level == LVL_M3),
				32'h1);
			if (i >= 23)
				check(32'(tx_level), 32'(h[0] ? LVL_P3 : LVL_M3));
			h[0] = (tx_level == LVL_P3);
			c += int'(tx_level == LVL_P3);
		end
		check(32'(c > 0 && c < 40), 32'h1);
		$display("test two-level ones done");
		@(posedge ref_clk);
		rst <= 1'b1;
		@(posedge ref_clk);
		rst <= 1'b0;
		apb(1'b0, TX_MODE_ADDR, 32'h0);
		check(rd, 32'(TX_MODE_RST));
		check(32'(tx_level), 32'(LVL_ZERO));
		$display("test second reset done");
		stop_test();
	end

	// Watchdog well beyond the expected run length
	initial begin
		#100000;
		fails++;
		stop_test();
	end
endmodule
